// ==== lcr_top.sv ====
module lcr_top
  import lcr_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Parallel host bus
  input wire logic i_e,
  input wire logic i_cs_n,
  input wire logic i_cmd_data_select,
  input wire logic i_rw,
  input wire logic [7:0] i_db,
  output logic [7:0] o_db,
  output logic o_db_oe_n,
  // Serial host port
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic i_ser_sel,
  // Hardware identity straps
  input wire logic [2:0] i_maker_id_bits,
  input wire logic [1:0] i_panel_size_id,
  // Panel settings
  output logic o_panel_on,
  output logic [6:0] o_start_line,
  output logic [6:0] o_first_row,
  output logic [7:0] o_duty,
  output logic o_booster_level_select,
  output logic o_instruction_bank_select,
  output logic [3:0] o_scan_rate_field,
  output logic o_symbol_row
);

  // State of the block outside the queue and RAM
  typedef struct packed {
    lcr_pins_s s1;
    lcr_pins_s s2;
    logic e_q;
    logic scl_q;
    logic [7:0] sh;
    logic [2:0] bcnt;
    logic [7:0] init_cnt;
    logic init;
    logic [4:0] page;
    logic [7:0] col;
    logic [7:0] col_save;
    logic modrd;
    logic on;
    logic [6:0] sline;
    logic [6:0] frow;
    logic [7:0] duty;
    logic boost;
    logic bank;
    logic sym;
    logic [3:0] scan;
    lcr_pend_e pend;
    logic [1:0] hold;
    logic rd_adv;
    logic ld;
    logic [7:0] rdbuf;
    logic [7:0] dout;
    logic oe_n;
    logic push;
    lcr_word_s pword;
    logic we;
    logic [ADDR_W-1:0] waddr;
    logic [7:0] wdata;
  } lcr_top_s;

  // Reset image; init flag set and counter loaded
  localparam lcr_top_s RST_VAL = '{
    init: 1'b1,
    init_cnt: 8'(INIT_CYC),
    boost: BOOST_RST,
    bank: BANK_RST,
    duty: DUTY_RST,
    scan: SCAN_RST,
    oe_n: 1'b1,
    pend: LCR_PEND_NONE,
    default: '0
  };

  lcr_top_s r, n;
  lcr_pins_s pins;
  lcr_word_s fifo_word;
  logic fifo_rdy;
  logic fifo_vld;
  logic pop;
  logic [7:0] mem_rdata;
  logic [ADDR_W-1:0] addr;
  logic busy;
  logic [7:0] status;
  logic e_rise, e_fall, scl_rise;

  // Gather pins for the two-stage synchroniser
  always_comb begin
    pins.e = i_e;
    pins.cs_n = i_cs_n;
    pins.cmd_data_select = i_cmd_data_select;
    pins.rw = i_rw;
    pins.db = i_db;
    pins.scl = i_scl;
    pins.sda = i_sda;
    pins.ser_sel = i_ser_sel;
    pins.maker_id_bits = i_maker_id_bits;
    pins.panel_size_id = i_panel_size_id;
  end

  // Edges seen only on the second synchroniser stage
  assign e_rise = r.s2.e & ~r.e_q;
  assign e_fall = ~r.s2.e & r.e_q;
  assign scl_rise = r.s2.scl & ~r.scl_q;

  // RAM location from page and column
  assign addr = ADDR_W'(r.page) * COLS + ADDR_W'(r.col);

  // Busy covers init and a full queue of pending work
  assign busy = r.init | ~fifo_rdy; // see RULE6

  // Status byte
  always_comb begin
    status = '0;
    status[ST_BUSY] = busy; // see RULE5
    status[ST_ON] = r.on; // see RULE7
    status[ST_INIT] = r.init; // see RULE8
    status[4:2] = r.s2.maker_id_bits; // see RULE9
    status[1:0] = r.s2.panel_size_id; // see RULE9
  end

  // Executor takes a new word only when idle
  assign pop = (r.hold == 2'h0) & ~r.rd_adv & fifo_vld;

  // Column step with wrap after the last column
  function automatic logic [7:0] col_step(input logic [7:0] c);
    col_step = (c == COL_LAST) ? 8'h00 : c + 8'h01; // see RULE4
  endfunction

  // Next-state logic
  always_comb begin
    n = r;
    n.s1 = pins;
    n.s2 = r.s1;
    n.e_q = r.s2.e;
    n.scl_q = r.s2.scl;
    n.push = 1'b0;
    n.we = 1'b0;
    n.ld = 1'b0;

    // Init countdown after reset release
    if (r.init) begin
      if (r.init_cnt == 8'h00) begin
        n.init = 1'b0; // see RULE8
      end else begin
        n.init_cnt = r.init_cnt - 8'h01;
      end
    end

    // Parallel port, 6800 style strobe
    if (!r.s2.ser_sel && !r.s2.cs_n) begin
      if (e_rise && r.s2.rw) begin
        // Data reads give the prefetched byte, hence the dummy read
        n.dout = r.s2.cmd_data_select ? r.rdbuf : status; // see RULE1 RULE2 RULE5
        n.oe_n = 1'b0;
      end
      if (e_fall) begin
        n.oe_n = 1'b1;
        if (r.s2.rw && r.s2.cmd_data_select) begin
          n.rd_adv = 1'b1; // see RULE1
        end
        if (!r.s2.rw && !busy) begin
          // Writes while busy are dropped, not queued
          n.push = 1'b1; // see RULE6
          n.pword.cmd_data_select = r.s2.cmd_data_select;
          n.pword.byte_val = r.s2.db;
        end
      end
    end else begin
      n.oe_n = 1'b1;
    end

    // Serial port, write only, MSB first
    if (r.s2.ser_sel) begin
      n.oe_n = 1'b1; // see RULE3
      if (r.s2.cs_n) begin
        n.bcnt = 3'h0;
      end else if (scl_rise) begin
        n.sh = {r.sh[6:0], r.s2.sda};
        n.bcnt = r.bcnt + 3'h1;
        if (r.bcnt == 3'h7 && !busy) begin
          n.push = 1'b1; // see RULE6
          n.pword.cmd_data_select = r.s2.cmd_data_select;
          n.pword.byte_val = {r.sh[6:0], r.s2.sda};
        end
      end
    end

    // Prefetch capture one cycle after a read step; RAM was read before the step
    if (r.ld) begin // see RULE1
      n.rdbuf = mem_rdata;
    end

    // Executor
    if (r.hold != 2'h0) begin
      n.hold = r.hold - 2'h1;
    end else if (r.rd_adv) begin
      n.rd_adv = 1'b0;
      n.ld = 1'b1;
      n.hold = EXEC_HOLD;
      if (!r.modrd) begin
        n.col = col_step(r.col); // see RULE1 RULE13
      end
    end else if (pop) begin
      n.hold = EXEC_HOLD;
      if (fifo_word.cmd_data_select) begin
        // Display data write
        n.we = 1'b1; // see RULE4
        n.waddr = addr;
        n.wdata = fifo_word.byte_val;
        n.col = col_step(r.col); // see RULE4 RULE13
      end else begin
        exec_cmd(fifo_word.byte_val);
      end
    end
  end

  // Instruction decode; writes fields of n
  task automatic exec_cmd(input logic [7:0] b);
    if (r.pend != LCR_PEND_NONE) begin
      n.pend = LCR_PEND_NONE;
      unique case (r.pend)
        LCR_PEND_MODE: begin
          n.scan = b[7:4]; // see RULE23
          n.boost = b[MODE_BOOST]; // see RULE21 RULE23
          n.bank = b[MODE_BANK]; // see RULE22 RULE23
        end
        LCR_PEND_SLINE: begin
          n.sline = b[6:0]; // see RULE17
        end
        LCR_PEND_FROW: begin
          n.frow = b[6:0]; // see RULE18
        end
        LCR_PEND_DUTY: begin
          // Out of range ratios leave the duty untouched
          if (r.sym) begin
            if (b >= DUTY_MIN_SYM && b <= DUTY_MAX_SYM) begin
              n.duty = b; // see RULE20
            end
          end else if (b >= DUTY_MIN && b <= DUTY_MAX) begin
            n.duty = b; // see RULE19
          end
        end
        default: begin
          n.pend = LCR_PEND_NONE;
        end
      endcase
    end else if (r.bank) begin
      // Second bank only knows mode set here
      if (b == OP_MODE) begin
        n.pend = LCR_PEND_MODE; // see RULE22
      end
    end else if (b[7:4] == OP_PAGE) begin
      n.page = {1'b0, b[3:0]}; // see RULE10 RULE11
    end else if (b[7:4] == OP_COL_HI) begin
      n.col[7:4] = b[3:0]; // see RULE12
    end else if (b[7:4] == OP_COL_LO) begin
      n.col[3:0] = b[3:0]; // see RULE12
    end else if (b == OP_MODRD_SET) begin
      if (!r.modrd) begin
        n.modrd = 1'b1; // see RULE13
        n.col_save = r.col; // see RULE14
      end
    end else if (b == OP_MODRD_CLR) begin
      if (r.modrd) begin
        n.modrd = 1'b0;
        n.col = r.col_save; // see RULE14
      end
    end else if (b[7:1] == OP_DISP) begin
      // Other settings still update while dark
      n.on = b[0]; // see RULE15 RULE16
    end else if (b[7:1] == OP_SYM) begin
      n.sym = b[0];
      if (b[0]) begin
        n.page = PAGE_SYM; // see RULE10
      end
    end else if (b[7:2] == OP_SLINE) begin
      n.pend = LCR_PEND_SLINE; // see RULE17
    end else if (b[7:2] == OP_FROW) begin
      n.pend = LCR_PEND_FROW; // see RULE18
    end else if (b[7:2] == OP_DUTY) begin
      n.pend = LCR_PEND_DUTY; // see RULE19
    end else if (b == OP_MODE) begin
      n.pend = LCR_PEND_MODE; // see RULE23
    end
  endtask

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      r <= RST_VAL;
    end else begin
      r <= n;
    end
  end

  // Queue between host port and executor; its inverted ready feeds the busy flag with init
  lcr_fifo #(
    .W(FIFO_W),
    .D(FIFO_DEPTH)
  ) u_fifo (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_valid(r.push),
    .o_ready(fifo_rdy),
    .i_data(r.pword),
    .o_valid(fifo_vld),
    .i_ready(pop),
    .o_data(fifo_word)
  );

  // Display RAM, 17 pages of 160 columns
  lcr_ram #(
    .W(DW),
    .D(RAM_DEPTH),
    .AW(ADDR_W)
  ) u_ram (
    .i_clk(i_clk),
    .i_we(r.we),
    .i_waddr(r.waddr),
    .i_wdata(r.wdata),
    .i_raddr(addr),
    .o_rdata(mem_rdata)
  );

  // Outputs straight from state
  assign o_db = r.dout;
  assign o_db_oe_n = r.oe_n;
  assign o_panel_on = r.on; // see RULE16
  assign o_start_line = r.sline;
  assign o_first_row = r.frow;
  assign o_duty = r.duty;
  assign o_booster_level_select = r.boost;
  assign o_instruction_bank_select = r.bank;
  assign o_scan_rate_field = r.scan;
  assign o_symbol_row = r.sym;

endmodule // lcr_top

// ==== lcr_pkg.sv ====
// What this block does
// RULE1: Data read returns byte at current page and column, then column advances by one.
// RULE2: Host does one dummy data read after loading a new column address.
// RULE3: Serial host port never returns display data; reads work on parallel port only.
// RULE4: Data write stores byte at page and column; column increments, wraps to zero.
// RULE5: Status byte: busy bit 7, on bit 6, init bit 5, maker 4..2, size 1..0.
// RULE6: Busy reads one during init or internal work; instructions then rejected. Code raises busy only for init or a full queue.
// RULE7: Display-on status bit reads zero when off, one when on.
// RULE8: Init progress flag reads one while reset initialization runs, else zero.
// RULE9: Maker and panel size ID bits follow the hardware selection inputs.
// RULE10: Page instruction 1011 plus 4-bit page field selects pages 0 to 15.
// RULE11: Loading a page address only moves the RAM access location.
// RULE12: Column loaded by two nibble instructions forming an 8-bit column 0 to 159.
// RULE13: In modify-read mode data reads hold the column; writes still increment.
// RULE14: Leaving modify-read restores the column held when the mode was entered.
// RULE15: Display on/off instruction sets panel on from its panel on bit.
// RULE16: With display off instructions still execute; panel stays dark.
// RULE17: Two-byte instruction loads 7-bit start line shown on top row driver.
// RULE18: Two-byte instruction loads 7-bit first row field, moving visible window.
// RULE19: Two-byte partial display sets duty 16 to 128; other values ignored.
// RULE20: With symbol row enabled the valid duty range becomes 17 to 129.
// RULE21: Booster level select: zero gives level 1, one gives level 2, default 2.
// RULE22: Instruction bank select defaults to zero and picks the accepted instruction set.
// RULE23: Mode set second byte: scan rate 7..4, booster bit 2, bank bit 0.
// RULE24: Host loads both column nibbles and page before any data burst.
package lcr_pkg;

  // Display RAM geometry
  localparam int DW = 8;
  localparam logic [11:0] COLS = 12'h0A0;
  localparam logic [7:0] COL_LAST = 8'h9F;
  localparam logic [4:0] PAGE_SYM = 5'h10;
  localparam int ADDR_W = 12;
  localparam int RAM_DEPTH = 2720;

  // Write FIFO
  localparam int FIFO_W = 9;
  localparam int FIFO_DEPTH = 8;

  // Timing
  localparam int CLK_NS = 8;
  localparam int INIT_NS = 1000;
  localparam int INIT_CYC = (INIT_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [1:0] EXEC_HOLD = 2'h2;

  // Instruction codes
  localparam logic [3:0] OP_PAGE = 4'hB;
  localparam logic [3:0] OP_COL_HI = 4'h1;
  localparam logic [3:0] OP_COL_LO = 4'h0;
  localparam logic [7:0] OP_MODRD_SET = 8'hE0;
  localparam logic [7:0] OP_MODRD_CLR = 8'hEE;
  localparam logic [6:0] OP_DISP = 7'h57;
  localparam logic [6:0] OP_SYM = 7'h51;
  localparam logic [5:0] OP_SLINE = 6'h10;
  localparam logic [5:0] OP_FROW = 6'h11;
  localparam logic [5:0] OP_DUTY = 6'h12;
  localparam logic [7:0] OP_MODE = 8'h38;

  // Status and mode byte fields
  localparam int ST_BUSY = 7;
  localparam int ST_ON = 6;
  localparam int ST_INIT = 5;
  localparam int MODE_BOOST = 2;
  localparam int MODE_BANK = 0;

  // Duty limits
  localparam logic [7:0] DUTY_MIN = 8'h10;
  localparam logic [7:0] DUTY_MAX = 8'h80;
  localparam logic [7:0] DUTY_MIN_SYM = 8'h11;
  localparam logic [7:0] DUTY_MAX_SYM = 8'h81;

  // Reset values
  localparam logic BOOST_RST = 1'b1;
  localparam logic BANK_RST = 1'b0;
  localparam logic [7:0] DUTY_RST = 8'h80;
  localparam logic [3:0] SCAN_RST = 4'h0;

  // Second byte awaited by the decoder
  typedef enum logic [2:0] {
    LCR_PEND_NONE = 3'b000,
    LCR_PEND_MODE = 3'b001,
    LCR_PEND_SLINE = 3'b010,
    LCR_PEND_FROW = 3'b011,
    LCR_PEND_DUTY = 3'b100
  } lcr_pend_e;

  // Host pins sampled together
  typedef struct packed {
    logic e;
    logic cs_n;
    logic cmd_data_select;
    logic rw;
    logic [7:0] db;
    logic scl;
    logic sda;
    logic ser_sel;
    logic [2:0] maker_id_bits;
    logic [1:0] panel_size_id;
  } lcr_pins_s;

  // Word queued for execution
  typedef struct packed {
    logic cmd_data_select;
    logic [7:0] byte_val;
  } lcr_word_s;

endpackage

// ==== lcr_fifo.sv ====
module lcr_fifo #(
  parameter int W = 9,
  parameter int D = 8
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Fill side
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [W-1:0] i_data,
  // Drain side
  output logic o_valid,
  input wire logic i_ready,
  output logic [W-1:0] o_data
);
  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW:0] wp;
    logic [AW:0] rp;
  } lcr_fifo_s;

  lcr_fifo_s r, n;
  logic full, empty;

  // Extra pointer bit tells full from empty
  assign empty = (r.wp == r.rp);
  assign full = (r.wp[AW-1:0] == r.rp[AW-1:0]) && (r.wp[AW] != r.rp[AW]);
  assign o_ready = ~full;
  assign o_valid = ~empty;
  assign o_data = r.mem[r.rp[AW-1:0]];

  // Pointer and storage update
  always_comb begin
    n = r;
    if (i_valid && !full) begin
      n.mem[r.wp[AW-1:0]] = i_data;
      n.wp = r.wp + 1'b1;
    end
    if (i_ready && !empty) begin
      n.rp = r.rp + 1'b1;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end
endmodule // lcr_fifo

// ==== lcr_ram.sv ====
module lcr_ram #(
  parameter int W = 8,
  parameter int D = 2720,
  parameter int AW = 12
) (
  // Clock
  input wire logic i_clk,
  // Write port
  input wire logic i_we,
  input wire logic [AW-1:0] i_waddr,
  input wire logic [W-1:0] i_wdata,
  // Read port, one cycle latency
  input wire logic [AW-1:0] i_raddr,
  output logic [W-1:0] o_rdata
);
  logic [W-1:0] mem [D];
  logic [W-1:0] rdata_r;

  // No reset: RAM contents are undefined after power-up anyway
  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
    rdata_r <= mem[i_raddr];
  end

  assign o_rdata = rdata_r;
endmodule // lcr_ram

// ==== lcr_top_props.sv ====
module lcr_top_props (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Host pins
  input wire logic i_e,
  input wire logic i_cs_n,
  input wire logic i_cmd_data_select,
  input wire logic i_rw,
  input wire logic i_ser_sel,
  input wire logic [2:0] i_maker_id_bits,
  input wire logic [1:0] i_panel_size_id,
  // Watched outputs
  input wire logic [7:0] o_db,
  input wire logic o_db_oe_n,
  input wire logic o_panel_on,
  input wire logic [6:0] o_start_line,
  input wire logic [7:0] o_duty,
  input wire logic o_booster_level_select,
  input wire logic o_instruction_bank_select,
  input wire logic o_symbol_row
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // Strobe released while selected
  sequence s_strobe_end;
    $fell(i_e) ##0 !i_cs_n;
  endsequence
  // Status read in progress
  sequence s_status_out;
    !o_db_oe_n && !i_cmd_data_select;
  endsequence
  AST_OE_DROPS: assert property (s_strobe_end |-> ##[1:6] o_db_oe_n)
    else $error("read drive outlives strobe");
  AST_OE_CAUSE: assert property ($fell(o_db_oe_n) |-> i_e && i_rw && !i_cs_n)
    else $error("bus driven without read strobe");
  AST_SER_NO_READ: assert property (i_ser_sel [*5] |-> o_db_oe_n)
    else $error("bus driven in serial mode");
  AST_IDS: assert property (s_status_out |-> o_db[4:0] == {i_maker_id_bits, i_panel_size_id})
    else $error("id bits differ from straps");
  AST_ON_BIT: assert property (s_status_out |-> o_db[6] == o_panel_on)
    else $error("on bit differs from panel state");
  AST_INIT_BUSY: assert property (s_status_out ##0 o_db[5] |-> o_db[7])
    else $error("init without busy");
  AST_DUTY_PLAIN: assert property ($changed(o_duty) && !o_symbol_row |-> o_duty inside {[8'h10:8'h80]})
    else $error("duty out of range");
  AST_DUTY_SYM: assert property ($changed(o_duty) && o_symbol_row |-> o_duty inside {[8'h11:8'h81]})
    else $error("duty out of symbol range");
  AST_BANK1_HOLD: assert property (o_instruction_bank_select && $past(o_instruction_bank_select) |-> $stable(o_panel_on) && $stable(o_start_line))
    else $error("bank 1 executed a bank 0 word");
  AST_RST_VALUES: assert property ($fell(i_rst) |-> o_duty == 8'h80 && o_booster_level_select && !o_instruction_bank_select)
    else $error("wrong settings after reset");
endmodule  // lcr_top_props

// ==== lcr_host.sv ====
module lcr_host (
  // Clock
  input wire logic i_clk,
  // Host pins
  output logic o_e,
  output logic o_cs_n,
  output logic o_cmd_data_select,
  output logic o_rw,
  output logic [7:0] o_db,
  output logic o_scl,
  output logic o_sda,
  output logic o_ser_sel,
  // Bus as seen by the host
  input wire logic [7:0] i_db
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle levels; serial clock stands high outside frames
  initial begin
    o_e = 1'b0;
    o_cs_n = 1'b1;
    o_cmd_data_select = 1'b0;
    o_rw = 1'b1;
    o_db = 8'h00;
    o_scl = 1'b1;
    o_sda = 1'b1;
    o_ser_sel = 1'b0;
  end
  // One strobe cycle; 8 clocks each phase covers the 6 clock minimum
  task automatic access(input logic cd, input logic rw, input logic [7:0] wd,
                        output logic [7:0] rd);
    @(posedge i_clk);
    o_cs_n <= 1'b0;
    o_cmd_data_select <= cd;
    o_rw <= rw;
    o_db <= rw ? ~o_db : wd;  // Released bus never holds the last byte
    o_e <= 1'b1;
    repeat (8) @(posedge i_clk);
    rd = i_db;
    o_e <= 1'b0;
    repeat (8) @(posedge i_clk);
    o_cs_n <= 1'b1;
  endtask
  // Poll status until the busy bit clears
  task automatic wait_ready(output logic ok);
    logic [7:0] s;
    ok = 1'b0;
    for (int n = 0; n < 40 && !ok; n++) begin
      access(1'b0, 1'b1, 8'h00, s);
      ok = (s[7] === 1'b0);
    end
  endtask
  // Port selection strap
  task automatic set_serial(input logic s);
    @(posedge i_clk);
    o_ser_sel <= s;
    repeat (4) @(posedge i_clk);
  endtask
  // Serial byte, MSB first, 64 ns clock
  task automatic ser_byte(input logic cd, input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      @(posedge i_clk);
      o_cs_n <= 1'b0;
      o_cmd_data_select <= cd;
      o_sda <= b[i];
      o_scl <= 1'b0;
      repeat (4) @(posedge i_clk);
      o_scl <= 1'b1;
      repeat (3) @(posedge i_clk);
    end
    repeat (4) @(posedge i_clk);
    o_cs_n <= 1'b1;
  endtask
endmodule  // lcr_host

// ==== lcr_tb.sv ====
module testbench
  import lcr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic e, cs_n, cds, rw, scl, sda, ser_sel, oe_n, on, boost, bank, sym, ok;
  logic oe_low = 1'b0;
  // Strap values are arbitrary
  logic [2:0] mk = 3'h5;
  logic [1:0] sz = 2'h1;
  logic [7:0] hdb, db, duty, r;
  logic [6:0] sline, frow;
  logic [3:0] scan;
  logic [7:0] dv [6] = '{8'h10, 8'h0F, 8'h81, 8'h80, 8'h81, 8'h10};
  logic [7:0] de [6] = '{8'h10, 8'h10, 8'h10, 8'h80, 8'h81, 8'h81};
  int error_cnt = 0;
  int compares = 0;
  int cycles = 0;
  always #4 clk = ~clk;
  // Released bus shows the inverse of the last byte
  lcr_host host_u (.i_clk(clk), .o_e(e), .o_cs_n(cs_n), .o_cmd_data_select(cds), .o_rw(rw),
    .o_db(hdb), .o_scl(scl), .o_sda(sda), .o_ser_sel(ser_sel), .i_db(oe_n ? ~db : db));
  lcr_top dut_u (.i_clk(clk), .i_rst(rst), .i_e(e), .i_cs_n(cs_n), .i_cmd_data_select(cds),
    .i_rw(rw), .i_db(hdb), .o_db(db), .o_db_oe_n(oe_n), .i_scl(scl), .i_sda(sda),
    .i_ser_sel(ser_sel), .i_maker_id_bits(mk), .i_panel_size_id(sz), .o_panel_on(on),
    .o_start_line(sline), .o_first_row(frow), .o_duty(duty), .o_booster_level_select(boost),
    .o_instruction_bank_select(bank), .o_scan_rate_field(scan), .o_symbol_row(sym));
  task automatic tally_and_finish;
    if (error_cnt == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Instruction write, then room for the queue to execute it
  task automatic cmd(input logic [7:0] b);
    host_u.access(1'b0, 1'b0, b, r);
    repeat (4) @(posedge clk);
  endtask
  task automatic two(input logic [7:0] a, input logic [7:0] b);
    cmd(a);
    cmd(b);
  endtask
  task automatic dat(input logic [7:0] b);
    host_u.access(1'b1, 1'b0, b, r);
  endtask
  task automatic loc(input logic [3:0] pg, input logic [7:0] col);
    cmd({OP_PAGE, pg});
    cmd({OP_COL_HI, col[7:4]});
    cmd({OP_COL_LO, col[3:0]});
  endtask
  task automatic rd_next(input string what, input logic [7:0] exp);
    host_u.access(1'b1, 1'b1, 8'h00, r);
    check(what, exp, r);
  endtask
  // Queue drains first; dummy read discarded
  task automatic rd_first(input string what, input logic [7:0] exp);
    repeat (30) @(posedge clk);
    host_u.access(1'b1, 1'b1, 8'h00, r);
    rd_next(what, exp);
  endtask
  task automatic status(input logic [7:0] exp);
    host_u.access(1'b0, 1'b1, 8'h00, r);
    check("status", exp, r);
  endtask
  // Main sequence
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    status(8'hB5);
    cmd({OP_DISP, 1'b1});
    host_u.wait_ready(ok);
    check("ready", 8'h01, {7'h0, ok});
    status(8'h15);
    check("duty", DUTY_RST, duty);
    check("boost", 8'h01, {7'h0, boost});
    check("bank", 8'h00, {7'h0, bank});
    cmd({OP_DISP, 1'b1});
    status(8'h55);
    loc(4'h3, COL_LAST);
    dat(8'hA5);
    dat(8'h3C);
    loc(4'h4, 8'h00);
    dat(8'h5A);
    loc(4'h3, COL_LAST);
    rd_first("ram last", 8'hA5);
    rd_next("ram wrap", 8'h3C);
    loc(4'h4, 8'h00);
    rd_first("ram page", 8'h5A);
    loc(4'h3, COL_LAST);
    cmd(OP_MODRD_SET);
    rd_first("hold", 8'hA5);
    rd_next("hold", 8'hA5);
    dat(8'h77);
    dat(8'h66);
    cmd(OP_MODRD_CLR);
    rd_first("restore", 8'h77);
    rd_next("step", 8'h66);
    two({OP_SLINE, 2'b00}, 8'h7F);
    check("line", 8'h7F, {1'b0, sline});
    two({OP_FROW, 2'b00}, 8'h05);
    check("row", 8'h05, {1'b0, frow});
    // Duty boundaries, symbol row enabled before the fifth of six values
    foreach (dv[i]) begin
      if (i == 4) cmd({OP_SYM, 1'b1});
      two({OP_DUTY, 2'b00}, dv[i]);
      check("duty", de[i], duty);
    end
    two(OP_MODE, 8'hA5);
    check("mode", 8'hA3, {scan, 2'b00, boost, bank});
    cmd({OP_DISP, 1'b0});
    check("bank 1", 8'h01, {7'h0, on});
    two(OP_MODE, 8'h00);
    check("mode", 8'h00, {scan, 2'b00, boost, bank});
    cmd({OP_DISP, 1'b0});
    two({OP_SLINE, 2'b00}, 8'h22);
    cmd({OP_PAGE, 4'h5});
    check("line", 8'h22, {1'b0, sline});
    status(8'h15);
    @(posedge clk);
    mk <= 3'h2;
    sz <= 2'h3;
    status(8'h0B);
    host_u.set_serial(1'b1);
    host_u.ser_byte(1'b0, {OP_DISP, 1'b1});
    repeat (20) @(posedge clk);
    check("serial on", 8'h01, {7'h0, on});
    host_u.access(1'b1, 1'b1, 8'h00, r);
    check("serial read", 8'h00, {7'h0, oe_low});
    tally_and_finish();
  end
  // Bus drive monitor and hang guard
  always @(posedge clk) begin
    cycles++;
    if (!oe_n && ser_sel) oe_low <= 1'b1;
    if (cycles == 20000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
endmodule  // testbench
bind lcr_top lcr_top_props chk_u (.i_clk, .i_rst, .i_e, .i_cs_n, .i_cmd_data_select, .i_rw,
  .i_ser_sel, .i_maker_id_bits, .i_panel_size_id, .o_db, .o_db_oe_n, .o_panel_on,
  .o_start_line, .o_duty, .o_booster_level_select, .o_instruction_bank_select, .o_symbol_row);
